// File: rtl/gam_gpio_alt_mux.sv
// Behaviour
// RULE1 - Each of eight pins has an alternate function, chosen by its enable bit.
// RULE2 - Alternate function may override pin direction and driven level.
// RULE3 - Debounce and edge interrupt selections stay effective in alternate mode.
// RULE4 - Pin seven reference mode: drivers off, input ignored, no interrupts.
// RULE5 - Software should clear pin seven pulls in reference mode.
// RULE6 - Pin zero alternate: low-power control input, polarity set by direction bit.
// RULE7 - Pins one to three alternate: sequencer drives level; drive type selects style.
// RULE8 - Pin four alternate: slow clock out, push-pull or open-drain per drive type.
// RULE9 - Pin five alternate: buck zero voltage scaling select, with polarity and debounce.
// RULE10 - Pin six alternate: buck one voltage scaling select, with polarity and debounce.
// RULE11 - Pin seven alternate: presents buffered reference; other fields zero.
// RULE12 - General output push-pull or open-drain; direction 0 output, 1 input.
// RULE13 - General input: hi-z, pull-down or pull-up, with debounced interrupt detection.
// RULE14 - Selected edge sets pin flag and group flag; interrupt out unless masked.
// RULE15 - Inputs are synchronised before debounce and edge detection.
// RULE16 - Without alternate mode, pin follows only general settings.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "gam_regs.svh"
module gam_gpio_alt_mux import gam_pkg::*; #(
  parameter int NPIN = 8,
  parameter int DB_CNT_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic [NPIN-1:0] pullup_enable,
  output logic [NPIN-1:0] pulldown_enable,
  output logic reference_enable,
  input wire logic [2:0] power_sequencer,
  input wire logic slow_clock_out,
  output logic low_power_request,
  output logic buck_zero_voltage_scaling_select,
  output logic buck_one_voltage_scaling_select,
  output logic irq_out_n
);
  logic [NPIN-1:0] pin_direction_r, pin_direction_nxt;
  logic [NPIN-1:0] output_level_r, output_level_nxt;
  logic [NPIN-1:0] drive_type_r, drive_type_nxt;
  logic [NPIN-1:0] pullup_r, pullup_nxt;
  logic [NPIN-1:0] pulldown_r, pulldown_nxt;
  logic [NPIN-1:0] alt_function_enable_r, alt_function_enable_nxt;
  logic [2*NPIN-1:0] debounce_select_r, debounce_select_nxt;
  logic [2*NPIN-1:0] edge_irq_select_r, edge_irq_select_nxt;
  logic [NPIN-1:0] pin_edge_flag_r, pin_edge_flag_nxt;
  logic pin_group_irq_mask_r, pin_group_irq_mask_nxt;
  logic [NPIN-1:0] prev_r, prev_nxt;
  logic [NPIN-1:0] sync_lvl;
  logic [NPIN-1:0] input_level;
  logic [NPIN-1:0] edge_hit;
  logic [NPIN-1:0] drive_val;
  logic [NPIN-1:0] drive_en;
  logic [NPIN-1:0] pp_mode;
  logic [NPIN-1:0] is_out;
  logic wr_en;
  logic [31:0] rd_mux;

  gam_sync #(.WIDTH(NPIN)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pin_in),
    .sync_out(sync_lvl)
  ); // see RULE15

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      logic deb;
      logic rise;
      logic fall;
      gam_debounce #(.CNT_W(DB_CNT_W)) u_db (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(sync_lvl[g]),
        .dbnc_sel(debounce_select_r[2*g+1:2*g]),
        .level_out(deb)
      ); // see RULE3
      // Reference mode gates the input buffer off
      if (g == `GAM_PIN_REF) begin : g_ref
        assign input_level[g] = deb & ~alt_function_enable_r[g]; // see RULE4
      end else begin : g_norm
        assign input_level[g] = deb;
      end
      assign rise = input_level[g] & ~prev_r[g];
      assign fall = ~input_level[g] & prev_r[g];
      // Edge selection applies in both general and alternate mode
      assign edge_hit[g] = (edge_irq_select_r[2*g] & rise) | (edge_irq_select_r[2*g+1] & fall); // see RULE3
      // Output drive: alternate sources replace the level bit on pins 1..4
      if (g >= 1 && g <= 3) begin : g_seq
        assign drive_val[g] = alt_function_enable_r[g] ? power_sequencer[g-1] : output_level_r[g]; // see RULE7
        assign is_out[g] = alt_function_enable_r[g] | ~pin_direction_r[g]; // see RULE2
      end else if (g == `GAM_PIN_CLK) begin : g_clk
        assign drive_val[g] = alt_function_enable_r[g] ? slow_clock_out : output_level_r[g]; // see RULE8
        assign is_out[g] = alt_function_enable_r[g] | ~pin_direction_r[g];
      end else begin : g_in
        // Alternate here is an input or the reference: drivers forced off
        assign drive_val[g] = output_level_r[g];
        assign is_out[g] = ~alt_function_enable_r[g] & ~pin_direction_r[g]; // see RULE16
      end
      assign pp_mode[g] = drive_type_r[g]; // see RULE12
      // Open-drain only ever pulls low
      assign drive_en[g] = is_out[g] & (pp_mode[g] | ~drive_val[g]);
    end
  endgenerate

  assign pin_out = drive_val & pp_mode;
  assign pin_oe = drive_en;
  // Pulls follow software; pin 7 pulls are left to software to clear
  assign pullup_enable = pullup_r; // see RULE13
  assign pulldown_enable = pulldown_r;
  assign reference_enable = alt_function_enable_r[`GAM_PIN_REF]; // see RULE11

  // Polarity: direction 0 means active-low, 1 active-high
  always_comb begin
    low_power_request = alt_function_enable_r[`GAM_PIN_LPM] &
      (input_level[`GAM_PIN_LPM] ~^ pin_direction_r[`GAM_PIN_LPM]); // see RULE6
    buck_zero_voltage_scaling_select = alt_function_enable_r[`GAM_PIN_DVS0] &
      (input_level[`GAM_PIN_DVS0] ~^ pin_direction_r[`GAM_PIN_DVS0]); // see RULE9
    buck_one_voltage_scaling_select = alt_function_enable_r[`GAM_PIN_DVS1] &
      (input_level[`GAM_PIN_DVS1] ~^ pin_direction_r[`GAM_PIN_DVS1]); // see RULE10
  end

  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;

  always_comb begin
    pslverr = 1'b0;
    unique case (paddr)
      `GAM_OFS_DIR: rd_mux = {24'h000000, pin_direction_r};
      `GAM_OFS_OUT: rd_mux = {24'h000000, output_level_r};
      `GAM_OFS_DRV: rd_mux = {24'h000000, drive_type_r};
      `GAM_OFS_PU: rd_mux = {24'h000000, pullup_r};
      `GAM_OFS_PD: rd_mux = {24'h000000, pulldown_r};
      `GAM_OFS_AME: rd_mux = {24'h000000, alt_function_enable_r};
      `GAM_OFS_DBNC: rd_mux = {16'h0000, debounce_select_r};
      `GAM_OFS_EDGE: rd_mux = {16'h0000, edge_irq_select_r};
      `GAM_OFS_IN: rd_mux = {24'h000000, input_level};
      `GAM_OFS_FLAG: rd_mux = {23'h000000, |(pin_edge_flag_r), pin_edge_flag_r};
      `GAM_OFS_MASK: rd_mux = {31'h00000000, pin_group_irq_mask_r};
      `GAM_OFS_ALT: rd_mux = {29'h00000000, buck_one_voltage_scaling_select,
        buck_zero_voltage_scaling_select, low_power_request};
      default: begin
        rd_mux = 32'h00000000;
        pslverr = psel & penable;
      end
    endcase
  end

  always_comb begin
    pin_direction_nxt = pin_direction_r;
    output_level_nxt = output_level_r;
    drive_type_nxt = drive_type_r;
    pullup_nxt = pullup_r;
    pulldown_nxt = pulldown_r;
    alt_function_enable_nxt = alt_function_enable_r;
    debounce_select_nxt = debounce_select_r;
    edge_irq_select_nxt = edge_irq_select_r;
    pin_group_irq_mask_nxt = pin_group_irq_mask_r;
    pin_edge_flag_nxt = pin_edge_flag_r;
    prev_nxt = input_level;
    if (wr_en) begin
      unique case (paddr)
        `GAM_OFS_DIR: pin_direction_nxt = pwdata[NPIN-1:0];
        `GAM_OFS_OUT: output_level_nxt = pwdata[NPIN-1:0];
        `GAM_OFS_DRV: drive_type_nxt = pwdata[NPIN-1:0];
        `GAM_OFS_PU: pullup_nxt = pwdata[NPIN-1:0];
        `GAM_OFS_PD: pulldown_nxt = pwdata[NPIN-1:0];
        `GAM_OFS_AME: alt_function_enable_nxt = pwdata[NPIN-1:0]; // see RULE1
        `GAM_OFS_DBNC: debounce_select_nxt = pwdata[2*NPIN-1:0];
        `GAM_OFS_EDGE: edge_irq_select_nxt = pwdata[2*NPIN-1:0];
        `GAM_OFS_FLAG: pin_edge_flag_nxt = pin_edge_flag_r & ~pwdata[NPIN-1:0];
        `GAM_OFS_MASK: pin_group_irq_mask_nxt = pwdata[0];
        default: ;
      endcase
    end
    // Set beats a same-cycle write-one clear; pin 7 never flags in reference mode
    pin_edge_flag_nxt = pin_edge_flag_nxt | (edge_hit &
      ~(NPIN'(alt_function_enable_r[`GAM_PIN_REF]) << `GAM_PIN_REF)); // see RULE14, see RULE4
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_r <= `GAM_RST_DIR;
      output_level_r <= `GAM_RST_ZERO;
      drive_type_r <= `GAM_RST_ZERO;
      pullup_r <= `GAM_RST_ZERO;
      pulldown_r <= `GAM_RST_ZERO;
      alt_function_enable_r <= `GAM_RST_ZERO;
      debounce_select_r <= '0;
      edge_irq_select_r <= '0;
      pin_edge_flag_r <= '0;
      pin_group_irq_mask_r <= `GAM_RST_MASK;
      prev_r <= '0;
      prdata <= 32'h00000000;
    end else begin
      pin_direction_r <= pin_direction_nxt;
      output_level_r <= output_level_nxt;
      drive_type_r <= drive_type_nxt;
      pullup_r <= pullup_nxt;
      pulldown_r <= pulldown_nxt;
      alt_function_enable_r <= alt_function_enable_nxt;
      debounce_select_r <= debounce_select_nxt;
      edge_irq_select_r <= edge_irq_select_nxt;
      pin_edge_flag_r <= pin_edge_flag_nxt;
      pin_group_irq_mask_r <= pin_group_irq_mask_nxt;
      prev_r <= prev_nxt;
      // Data registered at setup so it is valid during access
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
    end
  end

  assign irq_out_n = ~(|pin_edge_flag_r & ~pin_group_irq_mask_r); // see RULE14
endmodule

// File: rtl/gam_regs.svh
`ifndef GAM_REGS_SVH
`define GAM_REGS_SVH
`define GAM_OFS_DIR 12'h000
`define GAM_OFS_OUT 12'h004
`define GAM_OFS_DRV 12'h008
`define GAM_OFS_PU 12'h00c
`define GAM_OFS_PD 12'h010
`define GAM_OFS_AME 12'h014
`define GAM_OFS_DBNC 12'h018
`define GAM_OFS_EDGE 12'h01c
`define GAM_OFS_IN 12'h020
`define GAM_OFS_FLAG 12'h024
`define GAM_OFS_MASK 12'h028
`define GAM_OFS_ALT 12'h02c
`define GAM_RST_DIR 8'hff
`define GAM_RST_ZERO 8'h00
`define GAM_RST_MASK 1'b1
`define GAM_DB_T0_US 0
`define GAM_DB_T1_US 8
`define GAM_DB_T2_US 16
`define GAM_DB_T3_US 32
`define GAM_CLK_MHZ 100
`define GAM_PIN_REF 7
`define GAM_PIN_LPM 0
`define GAM_PIN_CLK 4
`define GAM_PIN_DVS0 5
`define GAM_PIN_DVS1 6
`endif

// File: rtl/gam_pkg.sv
package gam_pkg;
  typedef enum logic [1:0] {GAM_EDGE_NONE, GAM_EDGE_RISE, GAM_EDGE_FALL, GAM_EDGE_BOTH} gam_edge_t;
  typedef enum logic [1:0] {GAM_DB_0, GAM_DB_1, GAM_DB_2, GAM_DB_3} gam_dbnc_t;
endpackage

// File: rtl/gam_sync.sv
`timescale 1ns/1ns
module gam_sync import gam_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end
  assign sync_out = sync_r;
endmodule

// File: rtl/gam_debounce.sv
`timescale 1ns/1ns
`include "gam_regs.svh"
module gam_debounce import gam_pkg::*; #(
  parameter int CNT_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level_in,
  input wire logic [1:0] dbnc_sel,
  output logic level_out
);
  localparam logic [CNT_W-1:0] CYC1 = CNT_W'(`GAM_DB_T1_US * `GAM_CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC2 = CNT_W'(`GAM_DB_T2_US * `GAM_CLK_MHZ);
  localparam logic [CNT_W-1:0] CYC3 = CNT_W'(`GAM_DB_T3_US * `GAM_CLK_MHZ);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic [CNT_W-1:0] limit;
  always_comb begin
    unique case (gam_dbnc_t'(dbnc_sel))
      GAM_DB_0: limit = '0;
      GAM_DB_1: limit = CYC1;
      GAM_DB_2: limit = CYC2;
      GAM_DB_3: limit = CYC3;
    endcase
    cnt_nxt = '0;
    lvl_nxt = lvl_r;
    // New level must hold for the whole window before it is taken
    if (level_in != lvl_r) begin
      if (cnt_r >= limit) begin
        lvl_nxt = level_in;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      lvl_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
    end
  end
  assign level_out = lvl_r;
endmodule

// File: verif/gam_gpio_alt_mux_sva.sv
`timescale 1ns/1ns
module gam_gpio_alt_mux_chk #(
  parameter int NPIN = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] pullup_enable,
  input wire logic reference_enable,
  input wire logic irq_out_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  a_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
  a_bad_addr: assert property (acc && paddr >= 12'h030 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_good_addr: assert property (acc && paddr <= 12'h02c && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_err_only_acc: assert property (pslverr |-> acc) else $error("pslverr outside access");
  a_read_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  a_ref_quiet: assert property (reference_enable |-> !pin_oe[7]) else $error("reference pin driven");
  a_reset_idle: assert property (!$past(presetn) |-> irq_out_n && pin_oe == '0 && pullup_enable == '0)
    else $error("state after reset wrong");
  // Interrupt may only drop away one or two cycles after a write access to any register
  a_irq_release: assert property ($rose(irq_out_n) |-> $past(acc && pwrite, 1) || $past(acc && pwrite, 2))
    else $error("interrupt released without write");
endmodule
bind gam_gpio_alt_mux gam_gpio_alt_mux_chk #(.NPIN(NPIN)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_oe(pin_oe), .pullup_enable(pullup_enable), .reference_enable(reference_enable), .irq_out_n(irq_out_n));

// File: verif/gam_board.sv
`timescale 1ns/1ns
module gam_board (
  input wire logic pclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_dn,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;
  // Floating pins flip each cycle so a stale level never passes as valid
  always_ff @(posedge pclk) last_r <= pin_in;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up[i] || pull_dn[i]) pin_in[i] = pull_up[i];
      else pin_in[i] = ~last_r[i];
    end
  end
endmodule

// File: verif/gam_gpio_alt_mux_test.sv
`timescale 1ns/1ns
`include "gam_regs.svh"
module gam_gpio_alt_mux_test;
  logic pclk, presetn, psel, penable, pwrite, sclk, err, pready, pslverr, ref_en, lpm, bz, bo, irq_out_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rs, q, r;
  logic [7:0] pin_in, pin_out, pin_oe, pu, pd, ext_en, ext_val;
  logic [2:0] seq;
  int cfg[16];
  int fails, total_checks;
  gam_gpio_alt_mux #(.NPIN(8), .DB_CNT_W(12)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_enable(pu),
    .pulldown_enable(pd), .reference_enable(ref_en), .power_sequencer(seq), .slow_clock_out(sclk),
    .low_power_request(lpm), .buck_zero_voltage_scaling_select(bz), .buck_one_voltage_scaling_select(bo),
    .irq_out_n(irq_out_n));
  gam_board brd_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pu), .pull_dn(pd),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state budget here; the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a < 12'h020) cfg[a[5:2]] = d;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", q & m, e);
  endtask
  // Expected {oe, out} from the shadow copy of the configuration
  function automatic logic [15:0] pins();
    logic [7:0] o;
    logic [7:0] e;
    logic s;
    for (int i = 0; i < 8; i++) begin
      s = cfg[1][i];
      if (cfg[5][i] && i >= 1 && i <= 3) s = seq[i-1];
      if (cfg[5][i] && i == 4) s = sclk;
      e[i] = (cfg[5][i] ? (i >= 1 && i <= 4) : !cfg[0][i]) && (cfg[2][i] || !s);
      o[i] = cfg[2][i] & s;
    end
    return {e, o};
  endfunction
  task automatic pchk();
    logic [15:0] x;
    @(negedge pclk);
    x = pins();
    chk("oe", pin_oe, x[15:8]);
    chk("out", pin_out & pin_oe, x[7:0] & x[15:8]);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Longest path is the 800-cycle debounce wait
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, sclk} = 5'b0;
    {paddr, pwdata, seq, ext_en, ext_val} = '0;
    rs = 32'd12812;
    foreach (cfg[i]) cfg[i] = 0;
    cfg[0] = 255;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`GAM_OFS_DIR, 32'hff, 32'hff);
    rd(`GAM_OFS_MASK, 32'h1, 32'h1);
    rd(12'h030, 32'hffffffff, 32'h0);
    chk("slverr", err, 1'b1);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `GAM_OFS_OUT, rnd() & 32'hff);
      apb(1'b1, `GAM_OFS_DRV, rnd() & 32'hff);
      apb(1'b1, `GAM_OFS_DIR, rnd() & 32'hff);
      apb(1'b1, `GAM_OFS_AME, k[0] ? 32'h1e : 32'h0);
      r = rnd();
      seq <= r[2:0];
      sclk <= r[3];
      pchk();
    end
    apb(1'b1, `GAM_OFS_AME, 32'h61);
    ext_en <= 8'h61;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `GAM_OFS_DIR, k[1] ? 32'hff : 32'h0);
      ext_val <= k[0] ? 8'hff : 8'h00;
      repeat (8) @(posedge pclk);
      chk("lpm", lpm, k[0] == k[1]);
      chk("dvs0", bz, k[0] == k[1]);
      chk("dvs1", bo, k[0] == k[1]);
    end
    apb(1'b1, `GAM_OFS_AME, 32'h20);
    @(negedge pclk);
    chk("lpm off", lpm, 1'b0);
    r = rnd();
    apb(1'b1, `GAM_OFS_PU, r & 32'hff);
    apb(1'b1, `GAM_OFS_PD, (r >> 8) & 32'hff);
    @(negedge pclk);
    chk("pulls", {pd, pu}, r[15:0]);
    apb(1'b1, `GAM_OFS_DBNC, 32'h400);
    apb(1'b1, `GAM_OFS_EDGE, 32'h400);
    apb(1'b1, `GAM_OFS_FLAG, 32'hff);
    apb(1'b1, `GAM_OFS_MASK, 32'h0);
    ext_val <= 8'h00;
    repeat (1000) @(posedge pclk);
    ext_val <= 8'hff;
    repeat (400) @(posedge pclk);
    rd(`GAM_OFS_FLAG, 32'h120, 32'h0);
    repeat (600) @(posedge pclk);
    rd(`GAM_OFS_FLAG, 32'h120, 32'h120);
    chk("irq", irq_out_n, 1'b0);
    apb(1'b1, `GAM_OFS_FLAG, 32'h20);
    repeat (3) @(posedge pclk);
    chk("irq", irq_out_n, 1'b1);
    apb(1'b1, `GAM_OFS_PU, 32'h0);
    apb(1'b1, `GAM_OFS_PD, 32'h0);
    // Reference mode first: pin 7 floats and toggles until it is gated off
    apb(1'b1, `GAM_OFS_AME, 32'h80);
    ext_en <= 8'h80;
    apb(1'b1, `GAM_OFS_EDGE, 32'hc000);
    for (int k = 0; k < 6; k++) begin
      ext_val <= ~ext_val;
      repeat (10) @(posedge pclk);
    end
    rd(`GAM_OFS_FLAG, 32'h180, 32'h0);
    rd(`GAM_OFS_IN, 32'h80, 32'h0);
    chk("ref", ref_en, 1'b1);
    pchk();
    end_of_test();
  end
endmodule
